// [swr_pkg.sv]
// package: constants, types and decoders of the sequencer hold and reset release
package swr_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_MS = 500;
  localparam int TIMEOUT_US = TIMEOUT_MS * 1000;
  localparam int SLOT_BASE_US = 32;
  localparam int HOLD_BASE_US = 512;
  localparam int REL_STEP_US = 1024;
  localparam int REL_COARSE_CODE = 32;
  localparam int REL_COARSE_SHIFT = 5;
  localparam int SLOT_CNT_W = 14;
  localparam int HOLD_CNT_W = 24;
  localparam int REL_CNT_W = 21;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] IDX_HOLD_SLOT = 12'h092;
  localparam logic [ADDR_W-1:0] IDX_HOLD_CFG = 12'h097;
  localparam logic [ADDR_W-1:0] IDX_REL_CFG = 12'h099;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_SLOT = IDX_HOLD_SLOT << 2;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_CFG = IDX_HOLD_CFG << 2;
  localparam logic [ADDR_W-1:0] ADDR_REL_CFG = IDX_REL_CFG << 2;
  localparam logic [ADDR_W-1:0] ADDR_SEQ_CTRL = 12'h300;
  localparam logic [ADDR_W-1:0] ADDR_SEQ_CMD = 12'h304;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h308;

  localparam int HOLD_DIR_LSB = 6;
  localparam int HOLD_TO_BIT = 5;
  localparam int HOLD_MODE_BIT = 4;
  localparam int REL_EVT_LSB = 6;
  localparam int CMD_GO_BIT = 8;
  localparam int CMD_SYS_BIT = 9;
  localparam int CMD_PWR_BIT = 10;

  localparam logic [7:0] HOLD_CFG_RST = 8'h00;
  localparam logic [7:0] REL_CFG_RST = 8'h00;
  localparam logic [3:0] HOLD_SLOT_RST = 4'h0;
  localparam logic [3:0] SLOT_LEN_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SLOT = 2'b01,
    ST_HOLD = 2'b10
  } swr_state_e;

  typedef enum logic [1:0] {
    EVT_WAKE = 2'b00,
    EVT_SYS = 2'b01,
    EVT_PWR = 2'b10,
    EVT_RST_EXIT = 2'b11
  } swr_evt_e;

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  function automatic logic [SLOT_CNT_W-1:0] slot_us(input logic [3:0] code);
    logic [SLOT_CNT_W-1:0] r;
    r = '0;
    if (code <= 4'h8) begin
      r = SLOT_CNT_W'((int'(code) + 1) * SLOT_BASE_US);
    end else if (code == 4'h9) begin
      r = SLOT_CNT_W'(12 * SLOT_BASE_US);
    end else if (code == 4'ha) begin
      r = SLOT_CNT_W'(14 * SLOT_BASE_US);
    end else begin
      r = SLOT_CNT_W'((16 * SLOT_BASE_US) << (code - 4'hb));
    end
    return r;
  endfunction

  function automatic logic [HOLD_CNT_W-1:0] hold_us(input logic [3:0] code);
    logic [HOLD_CNT_W-1:0] r;
    r = '0;
    if (code != 4'h0) begin
      r = HOLD_CNT_W'(HOLD_BASE_US << (code - 4'h1));
    end
    return r;
  endfunction

endpackage

// [swr_us_tick.sv]
// microsecond tick generator
`timescale 1ns/1ns
`default_nettype none
module swr_us_tick #(
  parameter int CYC = 250
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  logic [15:0] cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_reg == 16'(CYC - 1)) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [swr_release_timer.sv]
// system reset release delay timer
`timescale 1ns/1ns
`default_nettype none
module swr_release_timer
  import swr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic us_tick,
  input wire logic trigger,
  input wire logic [5:0] delay_code,
  output logic rst_out_n
);
  logic [REL_CNT_W-1:0] cnt_reg;
  logic [10:0] units;

  // fine steps up to 31, coarse steps of 32 above
  always_comb begin
    if (delay_code < 6'(REL_COARSE_CODE)) begin
      units = 11'(delay_code);
    end else begin
      units = 11'(delay_code - 6'd31) << REL_COARSE_SHIFT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      rst_out_n <= 1'b0;
    end else if (trigger) begin
      cnt_reg <= REL_CNT_W'(units * REL_STEP_US);
      rst_out_n <= (delay_code == 6'h00);
    end else if (us_tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
      rst_out_n <= (cnt_reg == REL_CNT_W'(1));
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_REL_ZERO: assert property (trigger && delay_code == 6'h00 |=> rst_out_n)
    else $error("zero delay did not release reset");
  AST_REL_HOLD: assert property (trigger && delay_code != 6'h00 |=> !rst_out_n)
    else $error("reset not asserted on trigger");
  AST_REL_FINE: assert property (trigger && delay_code == 6'd1
                                 |=> cnt_reg == REL_CNT_W'(REL_STEP_US))
    else $error("fine delay loaded wrong");
  AST_REL_COARSE: assert property (trigger && delay_code == 6'd32
                                   |=> cnt_reg == REL_CNT_W'(REL_COARSE_CODE * REL_STEP_US))
    else $error("coarse delay loaded wrong");
  AST_REL_LOW: assert property (!rst_out_n && cnt_reg > REL_CNT_W'(1) && !trigger
                                |=> !rst_out_n)
    else $error("reset released before delay elapsed");
endmodule
`default_nettype wire

// [swr_seq_hold_top.sv]
// top: sequencer hold slot, reset release timer and axi4-lite registers
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - The direction field lets the hold slot stall never, on up, on down or on both.
// - With hold source 0 the sequencer pauses at the hold slot until the wait pin is active.
// - With hold source 1 the sequencer starts the hold timer and pauses until it expires.
// - With timeout enabled a pin wait ends after 500 ms, otherwise it has no limit.
// - The timeout enable matters only for the pin hold source.
// - With hold source 1, hold duration code 0 gives no extra pause beyond the normal slot length.
// - Hold duration codes 1 to 15 give 512 us doubling up to about 8.4 s.
// - The release trigger field picks wake, system up, power up or reset exit.
// - System and power up events count whether from a register write or a pin.
// - Release delay code 0 releases the reset output right after the trigger.
// - Release delay codes 1 to 31 hold reset for code times 1.024 ms.
// - Release delay codes 32 to 63 hold reset for 1.024 ms times 32 times code minus 31.
// - The hold applies only at the slot named by the hold slot index.
// - The normal slot length comes from the slot length code, 32 us at code 0.
module swr_seq_hold_top
  import swr_pkg::*;
#(
  parameter int US_CYC = US_CYCLES,
  parameter int TIMEOUT_LIM_US = TIMEOUT_US
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic external_wait_input_pin,
  input wire logic external_wake_event,
  input wire logic system_domain_power_up_pin,
  input wire logic power_domain_power_up_pin,
  input wire logic leave_reset_mode,
  output logic system_reset_out_n,
  output logic [3:0] current_slot,
  output logic sequence_busy
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_m;
  logic [3:0] pin_s;
  logic [3:0] pin_d;
  logic [3:0] pin_rise;
  logic wait_pin;

  assign pin_raw = {power_domain_power_up_pin, system_domain_power_up_pin,
                    external_wake_event, external_wait_input_pin};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m <= 4'h0;
      pin_s <= 4'h0;
      pin_d <= 4'h0;
    end else begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  assign pin_rise = pin_s & ~pin_d;
  assign wait_pin = pin_s[0];

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  logic us_tick;

  swr_us_tick #(
    .CYC(US_CYC)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(us_tick)
  );

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_hs;
  logic w_hs;
  logic do_wr;
  logic ar_hs;
  logic rvalid_next;

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return a == ADDR_HOLD_SLOT || a == ADDR_HOLD_CFG || a == ADDR_REL_CFG ||
           a == ADDR_SEQ_CTRL || a == ADDR_SEQ_CMD || a == ADDR_STATUS;
  endfunction

  assign aw_hs = awvalid & awready;
  assign w_hs = wvalid & wready;
  assign do_wr = aw_full_reg & w_full_reg & ~bvalid;
  assign ar_hs = arvalid & arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      aw_full_reg <= ~do_wr & (aw_full_reg | aw_hs);
      w_full_reg <= ~do_wr & (w_full_reg | w_hs);
      awready <= do_wr | ~(aw_full_reg | aw_hs);
      wready <= do_wr | ~(w_full_reg | w_hs);
      if (aw_hs) begin
        aw_addr_reg <= {awaddr[ADDR_W-1:2], 2'b00};
      end
      if (w_hs) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp <= addr_known(aw_addr_reg) && aw_addr_reg != ADDR_STATUS ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] hold_cfg_reg;
  logic [7:0] rel_cfg_reg;
  logic [3:0] hold_slot_reg;
  logic [3:0] slot_len_reg;
  logic [1:0] hold_dir;
  logic hold_to_en;
  logic hold_mode;
  logic [3:0] hold_code;
  logic cmd_wr;
  logic cmd_go;
  logic cmd_sys;
  logic cmd_pwr;

  assign hold_dir = hold_cfg_reg[HOLD_DIR_LSB +: 2];
  assign hold_to_en = hold_cfg_reg[HOLD_TO_BIT];
  assign hold_mode = hold_cfg_reg[HOLD_MODE_BIT];
  assign hold_code = hold_cfg_reg[3:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cfg_reg <= HOLD_CFG_RST;
      rel_cfg_reg <= REL_CFG_RST;
      hold_slot_reg <= HOLD_SLOT_RST;
      slot_len_reg <= SLOT_LEN_RST;
    end else if (do_wr && w_strb_reg[0]) begin
      case (aw_addr_reg)
        ADDR_HOLD_CFG: hold_cfg_reg <= w_data_reg[7:0];
        ADDR_REL_CFG: rel_cfg_reg <= w_data_reg[7:0];
        ADDR_HOLD_SLOT: hold_slot_reg <= w_data_reg[3:0];
        ADDR_SEQ_CTRL: slot_len_reg <= w_data_reg[3:0];
        default: begin
        end
      endcase
    end
  end

  assign cmd_wr = do_wr && aw_addr_reg == ADDR_SEQ_CMD && w_strb_reg[1];
  assign cmd_go = cmd_wr && w_strb_reg[0] && w_data_reg[CMD_GO_BIT];
  assign cmd_sys = cmd_wr && w_data_reg[CMD_SYS_BIT];
  assign cmd_pwr = cmd_wr && w_data_reg[CMD_PWR_BIT];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  swr_state_e state_reg;
  logic [3:0] target_reg;
  logic dir_up_reg;
  logic [SLOT_CNT_W-1:0] slot_cnt_reg;
  logic [HOLD_CNT_W-1:0] hold_cnt_reg;
  logic timeout_flag_reg;
  logic go_ok;
  logic dir_new;
  logic dir_ok;
  logic take_hold;
  logic slot_done;
  logic enter_hold;
  logic hold_done;
  logic hold_timeout;
  logic advance;
  logic at_end;
  logic next_slot;

  assign go_ok = cmd_go && state_reg == ST_IDLE && w_data_reg[3:0] != current_slot;
  assign dir_new = go_ok ? (w_data_reg[3:0] > current_slot) : dir_up_reg;
  assign dir_ok = dir_up_reg ? hold_dir[0] : hold_dir[1];
  assign take_hold = current_slot == hold_slot_reg && dir_ok && (!hold_mode || hold_code != 4'h0);
  assign slot_done = state_reg == ST_SLOT && slot_cnt_reg == '0;
  assign enter_hold = slot_done && take_hold;
  assign hold_timeout = !hold_mode && hold_to_en && hold_cnt_reg == '0;
  assign hold_done = state_reg == ST_HOLD &&
                     (hold_mode ? hold_cnt_reg == '0 : (wait_pin || hold_timeout));
  assign advance = (slot_done && !take_hold) || hold_done;
  assign at_end = current_slot == target_reg;
  assign next_slot = go_ok || (advance && !at_end);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (go_ok) begin
          state_reg <= ST_SLOT;
        end
        ST_SLOT: if (enter_hold) begin
          state_reg <= ST_HOLD;
        end else if (advance && at_end) begin
          state_reg <= ST_IDLE;
        end
        ST_HOLD: if (hold_done) begin
          state_reg <= at_end ? ST_IDLE : ST_SLOT;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_slot <= 4'h0;
      target_reg <= 4'h0;
      dir_up_reg <= 1'b1;
    end else begin
      if (go_ok) begin
        target_reg <= w_data_reg[3:0];
      end
      dir_up_reg <= dir_new;
      if (next_slot) begin
        current_slot <= dir_new ? current_slot + 4'h1 : current_slot - 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_cnt_reg <= '0;
    end else if (next_slot) begin
      slot_cnt_reg <= slot_us(slot_len_reg);
    end else if (us_tick && slot_cnt_reg != '0) begin
      slot_cnt_reg <= slot_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt_reg <= '0;
    end else if (enter_hold) begin
      hold_cnt_reg <= hold_mode ? hold_us(hold_code) : HOLD_CNT_W'(TIMEOUT_LIM_US);
    end else if (state_reg == ST_HOLD && us_tick && hold_cnt_reg != '0) begin
      hold_cnt_reg <= hold_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_flag_reg <= 1'b0;
      sequence_busy <= 1'b0;
    end else begin
      if (enter_hold) begin
        timeout_flag_reg <= 1'b0;
      end else if (hold_done && hold_timeout && !wait_pin) begin
        timeout_flag_reg <= 1'b1;
      end
      sequence_busy <= go_ok || (sequence_busy && !(advance && at_end));
    end
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic sys_evt;
  logic pwr_evt;
  logic rel_trig;
  swr_evt_e rel_sel;

  assign sys_evt = pin_rise[2] || cmd_sys;
  assign pwr_evt = pin_rise[3] || cmd_pwr;
  assign rel_sel = swr_evt_e'(rel_cfg_reg[REL_EVT_LSB +: 2]);

  always_comb begin
    unique case (rel_sel)
      EVT_WAKE: rel_trig = pin_rise[1];
      EVT_SYS: rel_trig = sys_evt;
      EVT_PWR: rel_trig = pwr_evt;
      EVT_RST_EXIT: rel_trig = leave_reset_mode;
    endcase
  end

  swr_release_timer u_rel (
    .aclk(aclk),
    .aresetn(aresetn),
    .us_tick(us_tick),
    .trigger(rel_trig),
    .delay_code(rel_cfg_reg[5:0]),
    .rst_out_n(system_reset_out_n)
  );

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h00000000;
    case ({araddr[ADDR_W-1:2], 2'b00})
      ADDR_HOLD_CFG: rd_val[7:0] = hold_cfg_reg;
      ADDR_REL_CFG: rd_val[7:0] = rel_cfg_reg;
      ADDR_HOLD_SLOT: rd_val[3:0] = hold_slot_reg;
      ADDR_SEQ_CTRL: rd_val[3:0] = slot_len_reg;
      ADDR_STATUS: rd_val[12:0] = {target_reg, system_reset_out_n, timeout_flag_reg,
                                   dir_up_reg, state_reg, current_slot};
      default: rd_val = 32'h00000000;
    endcase
  end

  assign rvalid_next = ar_hs | (rvalid & ~rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= rvalid_next;
      arready <= ~rvalid_next & ~ar_hs;
      if (ar_hs) begin
        rdata <= rd_val;
        rresp <= addr_known({araddr[ADDR_W-1:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hold_end;
    state_reg == ST_HOLD ##1 state_reg != ST_HOLD;
  endsequence

  sequence s_slot_end_at_hold;
    slot_done && current_slot == hold_slot_reg && dir_ok;
  endsequence

  AST_DIR_SEL: assert property (state_reg == ST_HOLD
                                |-> (dir_up_reg ? hold_dir[0] : hold_dir[1]))
    else $error("hold taken in a disabled direction");
  AST_PIN_WAIT: assert property (state_reg == ST_HOLD && !hold_mode && !wait_pin && !hold_timeout
                                 |=> state_reg == ST_HOLD)
    else $error("pin wait left early");
  AST_TMR_WAIT: assert property (state_reg == ST_HOLD && hold_mode && hold_cnt_reg != '0
                                 |=> state_reg == ST_HOLD)
    else $error("timer hold left early");
  AST_TIMEOUT: assert property (state_reg == ST_HOLD && !hold_mode && hold_to_en &&
                                hold_cnt_reg == '0 |=> state_reg != ST_HOLD)
    else $error("timeout did not end the wait");
  AST_TO_IGNORED: assert property (state_reg == ST_HOLD && hold_mode && hold_cnt_reg != '0 &&
                                   hold_to_en |=> !timeout_flag_reg)
    else $error("timeout affected timer hold");
  AST_ZERO_CODE: assert property (s_slot_end_at_hold and hold_mode && hold_code == 4'h0
                                  |=> state_reg != ST_HOLD)
    else $error("code zero paused");
  AST_HOLD_LOAD: assert property (enter_hold && hold_mode && hold_code == 4'h1
                                  |=> hold_cnt_reg == HOLD_CNT_W'(HOLD_BASE_US))
    else $error("hold duration wrong");
  AST_HOLD_SLOT: assert property (state_reg == ST_HOLD |-> current_slot == hold_slot_reg)
    else $error("hold at wrong slot");
  AST_SLOT_LEN: assert property (next_slot && slot_len_reg == 4'h0
                                 |=> slot_cnt_reg == SLOT_CNT_W'(SLOT_BASE_US))
    else $error("slot length wrong");
  AST_RESUME: assert property (s_hold_end |-> state_reg == ST_IDLE ||
                               (state_reg == ST_SLOT && current_slot != $past(current_slot)))
    else $error("sequencer did not move on after hold");
endmodule
`default_nettype wire

// [swr_far_side.sv]
// far-side model: wait-pin driver and reset-output low-time monitor
`timescale 1ns/1ns
`default_nettype none
module swr_far_side (
  input wire logic aclk,
  input wire logic wait_req,
  input wire logic [15:0] wait_dly,
  output logic wait_pin,
  input wire logic rst_n,
  output logic [31:0] last_low
);
  logic [15:0] cnt_reg = 16'h0;
  logic [31:0] low_reg = 32'h0;
  // ----------------------------------------
  // wait pin, raised wait_dly cycles after request, low when released
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    cnt_reg <= wait_req ? cnt_reg + 16'h1 : 16'h0;
    wait_pin <= wait_req && (cnt_reg >= wait_dly);
  end
  // ----------------------------------------
  // length of the last low phase of the reset output
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    low_reg <= rst_n ? 32'h0 : low_reg + 32'h1;
    if (rst_n && low_reg != 32'h0) begin
      last_low <= low_reg;
    end
  end
endmodule
`default_nettype wire

// [swr_seq_hold_top_tb.sv]
// testbench: sequencer hold slot and reset release timing
`timescale 1ns/1ns
`default_nettype none
module swr_seq_hold_top_tb;
  import swr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, arready;
  logic bvalid, rvalid, wait_pin, rst_n, busy, wait_req = 1'b0;
  logic ev_wake = 1'b0, ev_pwr = 1'b0, ev_sys = 1'b0, lrm = 1'b0;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] slot;
  logic [15:0] wait_dly = '0;
  logic [31:0] last_low;
  logic [ADDR_W-1:0] ra [3] = '{ADDR_HOLD_SLOT, ADDR_HOLD_CFG, ADDR_REL_CFG};
  int n_fail = 0;
  int checked = 0;

  always #2 aclk = ~aclk;

  swr_seq_hold_top #(.US_CYC(2), .TIMEOUT_LIM_US(50)) u_swr_seq_hold_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .external_wait_input_pin(wait_pin), .external_wake_event(ev_wake),
    .system_domain_power_up_pin(ev_sys), .power_domain_power_up_pin(ev_pwr),
    .leave_reset_mode(lrm), .system_reset_out_n(rst_n), .current_slot(slot),
    .sequence_busy(busy));

  swr_far_side u_swr_far_side (
    .aclk(aclk), .wait_req(wait_req), .wait_dly(wait_dly), .wait_pin(wait_pin),
    .rst_n(rst_n), .last_low(last_low));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rng(input string n, input int v, input int lo, input int hi);
    chk(n, 32'(v >= lo && v <= hi), 32'h1);
  endtask

  task automatic finish_test();
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // bus master tasks
  // ----------------------------------------
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  // ----------------------------------------
  // scenario helpers
  // ----------------------------------------
  task automatic fire(input int e);
    case (e)
      0: ev_wake <= 1'b1;
      1: axw(ADDR_SEQ_CMD, 32'h200, rsp);
      2: ev_pwr <= 1'b1;
      4: axw(ADDR_SEQ_CMD, 32'h400, rsp);
      5: ev_sys <= 1'b1;
      default: lrm <= 1'b1;
    endcase
    @(posedge aclk);
    lrm <= 1'b0;
    repeat (3) @(posedge aclk);
    ev_wake <= 1'b0;
    ev_pwr <= 1'b0;
    ev_sys <= 1'b0;
  endtask

  task automatic relwait(input string n, input int lo, input int hi);
    while (rst_n === 1'b1) @(posedge aclk);
    while (rst_n === 1'b0) @(posedge aclk);
    @(posedge aclk);
    rng(n, last_low, lo, hi);
  endtask

  task automatic seq(input logic [7:0] cfg, input logic [3:0] tgt, input int dly,
                     input int lo, input int hi);
    int n;
    axw(ADDR_HOLD_CFG, {24'h0, cfg}, rsp);
    axw(ADDR_SEQ_CMD, {20'h0, 4'h1, 4'h0, tgt}, rsp);
    while (slot !== 4'h2) @(posedge aclk);
    chk("busy", 32'(busy), 32'h1);
    wait_req <= (dly > 0);
    wait_dly <= 16'(dly);
    n = 0;
    while (slot === 4'h2) begin
      @(posedge aclk);
      n++;
    end
    wait_req <= 1'b0;
    rng("hold slot dwell", n, lo, hi);
    while (busy === 1'b1) @(posedge aclk);
    chk("final slot", 32'(slot), 32'(tgt));
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (ra[i]) begin
      axr(ra[i], rd, rsp);
      chk("reset value", rd, 32'h0);
    end
    axr(12'h3fc, rd, rsp);
    chk("unmapped rdata", rd, 32'h0);
    chk("unmapped rresp", 32'(rsp), 32'(RESP_SLVERR));
    axw(ADDR_STATUS, 32'h0, rsp);
    chk("status write bresp", 32'(rsp), 32'(RESP_SLVERR));
    axw(ADDR_REL_CFG, 32'hc0, rsp);
    axr(ADDR_REL_CFG, rd, rsp);
    chk("release cfg readback", rd, 32'hc0);
    fire(3);
    chk("immediate release", 32'(rst_n), 32'h1);
    for (int t = 0; t < 4; t++) begin
      axw(ADDR_REL_CFG, {24'h0, 2'(t), 6'd1}, rsp);
      fire((t + 1) % 4);
      repeat (8) @(posedge aclk);
      chk("unselected event", 32'(rst_n), 32'h1);
      fire(t);
      relwait("delay code 1", 2044, 2056);
    end
    for (int t = 4; t < 6; t++) begin
      axw(ADDR_REL_CFG, {24'h0, 2'(t - 3), 6'd1}, rsp);
      fire(9 - t);
      relwait("other source", 2044, 2056);
    end
    axw(ADDR_REL_CFG, 32'he0, rsp);
    fire(3);
    relwait("delay code 32", 65530, 65546);
    axw(ADDR_HOLD_SLOT, 32'h2, rsp);
    seq(8'h40, 4'h4, 200, 198, 214);
    seq(8'h40, 4'h0, 0, 60, 70);
    seq(8'he0, 4'h4, 0, 158, 172);
    axr(ADDR_STATUS, rd, rsp);
    chk("timeout flag", {31'h0, rd[7]}, 32'h1);
    seq(8'hb1, 4'h0, 0, 1082, 1098);
    axw(ADDR_SEQ_CTRL, 32'h1, rsp);
    seq(8'hd0, 4'h4, 0, 124, 134);
    finish_test();
  end
endmodule
`default_nettype wire
